// ==== logic/adcpd_top.sv ====
// Phase delay and data-ready control for four converter channels.
// Assumes an APB master on clk_in and an asynchronous active-low hard reset pin.
`timescale 1ns/1ns
module adcpd_top #(
  parameter int MAX_PRE = 3
) (
  // Clock and resets.
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic hard_resetn_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Sample inputs from the modulators, one per channel.
  input wire logic [95:0] sample_in,
  // Data-ready pin, active low, with output enable active low.
  output logic sample_ready_strobe_n_out,
  output logic sample_ready_oe_n_out,
  output logic serial_out_oe_n_out,
  // Clock source control.
  output logic crystal_enable_out,
  output logic crystal_out_pulldown_out,
  // Modulator state.
  output logic [15:0] comparator_word_out,
  output logic modulator_clear_out
);
  initial begin
    if (MAX_PRE < 0 || MAX_PRE > 3) begin
      $error("MAX_PRE out of range");
    end
  end

  logic hard_rst_sync;
  logic in_reset;
  logic [23:0] pair_delay_reg;
  logic ready_link_select_reg;
  logic [2:0] osr_reg;
  logic [3:0] enable_reg;
  logic [3:0] channel_ready_flags_reg;
  logic external_clock_select_reg;
  logic [1:0] pre_reg;
  logic [1:0] pre_count_reg;
  logic tick;
  logic restart_reg;
  logic [3:0] chan_ready;
  logic [3:0] ready_event;
  logic [23:0] chan_data_reg [4];
  logic [31:0] rdata_next;
  logic wr_acc;
  logic rd_acc;
  logic [12:0] ratio;
  logic [12:0] half;
  logic signed [13:0] d01;
  logic signed [13:0] d23;
  logic [12:0] first [4];
  logic [3:0] lag_mask;
  logic [13:0] lag_max;
  logic pulse_reg;
  logic adcpd_cfg_unused;
  adcpd_pkg::adcpd_cfg_s cfg;

  adcpd_sync #(
    .RESET_VAL(1'b1)
  ) u_hard_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in & hard_resetn_in),
    .level_in(1'b0),
    .level_out(hard_rst_sync)
  );
  assign in_reset = hard_rst_sync;

  assign wr_acc = psel_in && penable_in && pwrite_in && !in_reset;
  assign rd_acc = psel_in && penable_in && !pwrite_in;
  assign pready_out = 1'b1;
  assign pslverr_out = 1'b0;

  assign cfg = '{delay01: pair_delay_reg[11:0], delay23: pair_delay_reg[23:12],
    osr_code: osr_reg, enable: enable_reg, link: ready_link_select_reg};
  assign adcpd_cfg_unused = 1'b0;

  // Configuration returns to defaults on hard reset.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pair_delay_reg <= adcpd_pkg::PAIR_DELAY_RST;
      ready_link_select_reg <= adcpd_pkg::LINK_RST;
      osr_reg <= adcpd_pkg::OSR_RST;
      enable_reg <= adcpd_pkg::EN_RST;
      external_clock_select_reg <= adcpd_pkg::EXTERNAL_CLOCK_SELECT_RST;
      pre_reg <= adcpd_pkg::PRE_RST;
    end else if (in_reset) begin
      pair_delay_reg <= adcpd_pkg::PAIR_DELAY_RST;
      ready_link_select_reg <= adcpd_pkg::LINK_RST;
      osr_reg <= adcpd_pkg::OSR_RST;
      enable_reg <= adcpd_pkg::EN_RST;
      external_clock_select_reg <= adcpd_pkg::EXTERNAL_CLOCK_SELECT_RST;
      pre_reg <= adcpd_pkg::PRE_RST;
    end else if (wr_acc) begin
      case (paddr_in)
        adcpd_pkg::ADDR_PAIR_DELAY: begin
          pair_delay_reg <= pwdata_in[23:0];
        end
        adcpd_pkg::ADDR_STATUS_COMM: begin
          ready_link_select_reg <= pwdata_in[adcpd_pkg::LINK_BIT];
          osr_reg <= pwdata_in[adcpd_pkg::OSR_LSB +: 3];
          enable_reg <= pwdata_in[adcpd_pkg::EN_LSB +: 4];
        end
        adcpd_pkg::ADDR_SECOND_CONFIG: begin
          external_clock_select_reg <= pwdata_in[adcpd_pkg::EXTERNAL_CLOCK_SELECT_BIT];
          pre_reg <= pwdata_in[adcpd_pkg::PRE_LSB +: 2];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      restart_reg <= 1'b1;
    end else begin
      restart_reg <= in_reset || (wr_acc && paddr_in == adcpd_pkg::ADDR_PAIR_DELAY);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pre_count_reg <= 2'h0;
    end else if (restart_reg || pre_count_reg >= pre_reg) begin
      pre_count_reg <= 2'h0;
    end else begin
      pre_count_reg <= pre_count_reg + 2'h1;
    end
  end
  assign tick = !restart_reg && (pre_count_reg >= pre_reg);

  // Ratio 32 shifted by the code; sign at log2(ratio)-1.
  assign ratio = 13'h0020 << osr_reg;
  assign half = ratio >> 1;

  // Mask above the sign bit and sign-extend.
  function automatic logic signed [13:0] ext_delay(input logic [11:0] f,
                                                  input logic [2:0] code);
    logic [11:0] m;
    logic s;
    m = f & ((12'h010 << code) - 12'h001);
    s = f[4'(4 + code)];
    ext_delay = s ? $signed({2'b11, m | ~((12'h010 << code) - 12'h001)}) :
                    $signed({2'b00, m});
  endfunction

  // Range fits half ratio by masking.
  assign d01 = ext_delay(cfg.delay01, cfg.osr_code);
  assign d23 = ext_delay(cfg.delay23, cfg.osr_code);

  // Odd at half ratio, even offset by delay.
  assign first[1] = half;
  assign first[3] = half;
  assign first[0] = 13'($signed({1'b0, half}) + d01);
  assign first[2] = 13'($signed({1'b0, half}) + d23);

  // Channel counters.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_chan
      adcpd_chan u_chan (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .restart_in(restart_reg),
        .tick_in(tick),
        .ratio_in(ratio),
        .first_in(first[g] == 13'h0000 ? ratio : first[g]),
        .ready_out(chan_ready[g])
      );
    end
  endgenerate

  // Most lagging enabled channel chosen by largest first offset.
  always_comb begin
    lag_max = 14'h0000;
    lag_mask = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (enable_reg[i] && {1'b0, first[i]} > lag_max) begin
        lag_max = {1'b0, first[i]};
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (enable_reg[i] && {1'b0, first[i]} == lag_max && lag_mask == 4'h0) begin
        lag_mask[i] = 1'b1;
      end
    end
  end

  // Update events follow the link mode.
  assign ready_event = ready_link_select_reg ?
                       ((|(chan_ready & lag_mask)) ? enable_reg : 4'h0) :
                       (chan_ready & enable_reg);

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < 4; i++) begin
        chan_data_reg[i] <= adcpd_pkg::ZERO_CODE;
      end
    end else if (restart_reg || in_reset) begin
      for (int i = 0; i < 4; i++) begin
        chan_data_reg[i] <= adcpd_pkg::ZERO_CODE;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (ready_event[i]) begin
          chan_data_reg[i] <= sample_in[i*24 +: 24];
        end
      end
    end
  end

  // Status read sets flags; update wins.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      channel_ready_flags_reg <= adcpd_pkg::READY_FLAGS_RST;
    end else if (restart_reg || in_reset) begin
      channel_ready_flags_reg <= adcpd_pkg::READY_FLAGS_RST;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (ready_event[i]) begin
          channel_ready_flags_reg[i] <= 1'b0;
        end else if (rd_acc && paddr_in == adcpd_pkg::ADDR_STATUS_COMM) begin
          channel_ready_flags_reg[i] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= |ready_event && !restart_reg && !in_reset;
    end
  end
  assign sample_ready_strobe_n_out = !pulse_reg;

  assign sample_ready_oe_n_out = in_reset;
  assign serial_out_oe_n_out = in_reset;

  // Comparator word 0011 and modulator clear.
  assign comparator_word_out = in_reset ? {4{adcpd_pkg::COMPARATOR_RST}} : 16'h0000;
  assign modulator_clear_out = restart_reg;

  assign crystal_enable_out = !external_clock_select_reg;
  assign crystal_out_pulldown_out = external_clock_select_reg;

  // APB read mux.
  always_comb begin
    rdata_next = 32'h00000000;
    case (paddr_in)
      adcpd_pkg::ADDR_PAIR_DELAY: rdata_next = {8'h00, pair_delay_reg};
      adcpd_pkg::ADDR_STATUS_COMM: rdata_next = {16'h0000, enable_reg, 1'b0, osr_reg,
                                                 3'h0, ready_link_select_reg,
                                                 channel_ready_flags_reg};
      adcpd_pkg::ADDR_SECOND_CONFIG: rdata_next = {26'h0, pre_reg, 3'h0,
                                                   external_clock_select_reg};
      8'h10: rdata_next = {8'h00, chan_data_reg[0]};
      8'h14: rdata_next = {8'h00, chan_data_reg[1]};
      8'h18: rdata_next = {8'h00, chan_data_reg[2]};
      8'h1c: rdata_next = {8'h00, chan_data_reg[3]};
      default: rdata_next = 32'h00000000;
    endcase
  end
  assign prdata_out = rdata_next;
endmodule

// ==== logic/adcpd_pkg.sv ====
// Package for the phase and data-ready control of a four-channel converter.
// Assumes one master clock domain; the registers are reached over APB.
package adcpd_pkg;
  // Register byte offsets.
  localparam logic [7:0] ADDR_PAIR_DELAY = 8'h00;
  localparam logic [7:0] ADDR_STATUS_COMM = 8'h04;
  localparam logic [7:0] ADDR_SECOND_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_CHAN_DATA0 = 8'h10;
  // Field positions.
  localparam int DELAY_W = 12;
  localparam int PAIR01_LSB = 0;
  localparam int PAIR23_LSB = 12;
  localparam int LINK_BIT = 4;
  localparam int OSR_LSB = 8;
  localparam int EN_LSB = 12;
  localparam int EXTERNAL_CLOCK_SELECT_BIT = 0;
  localparam int PRE_LSB = 4;
  // Reset values.
  localparam logic [23:0] PAIR_DELAY_RST = 24'h000000;
  localparam logic LINK_RST = 1'b1;
  localparam logic [2:0] OSR_RST = 3'h3;
  localparam logic [3:0] EN_RST = 4'hf;
  localparam logic [3:0] READY_FLAGS_RST = 4'hf;
  localparam logic EXTERNAL_CLOCK_SELECT_RST = 1'b0;
  localparam logic [1:0] PRE_RST = 2'h0;
  localparam logic [3:0] COMPARATOR_RST = 4'h3;
  localparam logic [23:0] ZERO_CODE = 24'h000000;
  // Timing.
  localparam int CLK_MHZ = 125;
  localparam int CLK_PERIOD_NS = 8;
  // Register bundle handed to the channel timing logic.
  typedef struct packed {
    logic [11:0] delay01;
    logic [11:0] delay23;
    logic [2:0] osr_code;
    logic [3:0] enable;
    logic link;
  } adcpd_cfg_s;
endpackage

// ==== logic/adcpd_sync.sv ====
// Two-flop synchroniser for one level crossing into the master clock.
// Assumes the input is asynchronous to clk_in.
`timescale 1ns/1ns
module adcpd_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Level in and out.
  input wire logic level_in,
  output logic level_out
);
  logic first_reg;

  // First flop feeds only the second.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      first_reg <= RESET_VAL;
      level_out <= RESET_VAL;
    end else begin
      first_reg <= level_in;
      level_out <= first_reg;
    end
  end
endmodule

// ==== logic/adcpd_chan.sv ====
// One channel: counts modulator ticks and emits a ready pulse per word period.
// Assumes a one-cycle modulator tick and a synchronous restart strobe.
`timescale 1ns/1ns
module adcpd_chan (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Control.
  input wire logic restart_in,
  input wire logic tick_in,
  input wire logic [12:0] ratio_in,
  input wire logic [12:0] first_in,
  // Event.
  output logic ready_out
);
  logic [12:0] count_reg;
  logic first_done_reg;
  logic [12:0] target;

  // The first word lands at the offset start, later ones every ratio ticks.
  assign target = first_done_reg ? ratio_in : first_in;

  // Tick counter, restarted together with every other channel.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_reg <= 13'h0000;
      first_done_reg <= 1'b0;
      ready_out <= 1'b0;
    end else if (restart_in) begin
      count_reg <= 13'h0000;
      first_done_reg <= 1'b0;
      ready_out <= 1'b0;
    end else begin
      ready_out <= 1'b0;
      if (tick_in) begin
        if (count_reg + 13'h0001 >= target) begin
          count_reg <= 13'h0000;
          first_done_reg <= 1'b1;
          ready_out <= 1'b1;
        end else begin
          count_reg <= count_reg + 13'h0001;
        end
      end
    end
  end
endmodule

// ==== sim/adcpd_chk.sv ====
// Checker for the phase and ready control block.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ns
module adcpd_chk #(
  parameter int MAX_PRE = 3
) (
  // Clock, resets and bus.
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic hard_resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] prdata_out,
  // Pins and modulator state.
  input wire logic sample_ready_strobe_n_out,
  input wire logic sample_ready_oe_n_out,
  input wire logic serial_out_oe_n_out,
  input wire logic crystal_enable_out,
  input wire logic crystal_out_pulldown_out,
  input wire logic [15:0] comparator_word_out,
  input wire logic modulator_clear_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Hard reset floats the pins, parks the comparators and zeroes the data.
  AST_HARD_FLOAT: assert property (!hard_resetn_in |=> sample_ready_oe_n_out &&
    serial_out_oe_n_out && sample_ready_strobe_n_out) else $error("pins driven in reset");
  AST_HARD_CMP: assert property (!hard_resetn_in |=> comparator_word_out == 16'h3333)
    else $error("comparator word wrong in reset");
  AST_RUN_CMP: assert property (hard_resetn_in [*4] |-> comparator_word_out == 16'h0000)
    else $error("comparator word stuck");
  AST_ZERO_CODE: assert property (!hard_resetn_in ##1 (!hard_resetn_in && psel_in &&
    paddr_in == adcpd_pkg::ADDR_CHAN_DATA0) |-> prdata_out[23:0] == adcpd_pkg::ZERO_CODE)
    else $error("data not zero in reset");
  AST_HARD_CLEAR: assert property ($rose(hard_resetn_in) |-> ##[1:4] modulator_clear_out)
    else $error("no restart after hard reset");
  // Clock source and delay writes.
  AST_CLK_SEL: assert property (crystal_enable_out != crystal_out_pulldown_out)
    else $error("clock select outputs agree");
  AST_CLK_DEF: assert property ($rose(resetn_in) |-> crystal_enable_out)
    else $error("crystal off after reset");
  AST_RESTART: assert property (psel_in && penable_in && pwrite_in && !sample_ready_oe_n_out &&
    paddr_in == adcpd_pkg::ADDR_PAIR_DELAY |=> modulator_clear_out) else $error("no restart");
  cover property (modulator_clear_out);
  cover property ($fell(sample_ready_strobe_n_out));
  cover property (psel_in && penable_in && paddr_in == adcpd_pkg::ADDR_STATUS_COMM);
endmodule
bind adcpd_top adcpd_chk #(.MAX_PRE(MAX_PRE)) adcpd_chk_i (.*);

// ==== sim/adcpd_host.sv ====
// Host model: watches the ready pin, counts each low pulse and stamps the first four.
// Assumes the bench resolves the pin level from the device enable.
`timescale 1ns/1ns
module adcpd_host (
  // Clock and pin.
  input wire logic clk_in,
  input wire logic arm_in,
  input wire logic pin_in,
  // Pulse record.
  output logic [7:0] count_out,
  output logic [15:0] stamp_out [4]
);
  logic [15:0] now_reg;
  // Counts cycles from arming and stamps the first four pulses; the clock is fixed.
  always_ff @(posedge clk_in) begin
    if (arm_in) begin
      now_reg <= 16'h0000;
      count_out <= 8'h00;
    end else begin
      now_reg <= now_reg + 16'h0001;
      if (!pin_in) begin
        if (count_out < 8'h04) stamp_out[count_out[1:0]] <= now_reg;
        count_out <= count_out + 8'h01;
      end
    end
  end
endmodule

// ==== sim/testbench.sv ====
// Bench for the phase and ready control block with a host model on the ready pin.
// Assumes the design, host model and checker are compiled first.
`timescale 1ns/1ns
module testbench;
  logic clk_in;
  logic resetn_in;
  logic hard_resetn_in;
  logic psel_in;
  logic penable_in;
  logic pwrite_in;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in;
  logic [31:0] prdata_out;
  logic pready_out;
  logic [95:0] sample_in;
  logic strobe_n;
  logic oe_n;
  logic soe_n;
  logic xtal_en;
  logic xtal_pd;
  logic [15:0] cmp_word;
  logic clear;
  logic arm;
  logic [7:0] cnt;
  logic [15:0] st [4];
  logic [31:0] rd;
  int n_mismatch;
  int checked;
  // The ready pin is pulled high while the device lets go of it.
  wire logic pin = oe_n ? 1'b1 : strobe_n;
  adcpd_top adcpd_top_i (
    .clk_in, .resetn_in, .hard_resetn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out(), .sample_in,
    .sample_ready_strobe_n_out(strobe_n), .sample_ready_oe_n_out(oe_n),
    .serial_out_oe_n_out(soe_n), .crystal_enable_out(xtal_en),
    .crystal_out_pulldown_out(xtal_pd), .comparator_word_out(cmp_word),
    .modulator_clear_out(clear)
  );
  adcpd_host adcpd_host_i (.clk_in, .arm_in(arm), .pin_in(pin), .count_out(cnt), .stamp_out(st));
  // Clock at 125 MHz.
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // Counts a comparison and reports a mismatch.
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; read data lands in rd at the accepting edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  // Arms the host and lets 70 cycles of pulses go by.
  task automatic watch();
    arm <= 1'b1;
    @(posedge clk_in);
    arm <= 1'b0;
    repeat (69) @(posedge clk_in);
  endtask
  task automatic t_defaults();
    apb(1'b1, 8'h04, 32'h0000f310);
    apb(1'b0, 8'h04, 32'h0);
    compare("flags_ro", 32'h0000f31f, rd);
    apb(1'b0, 8'h04, 32'h0);
    compare("status", 32'h0000f31f, rd);
    apb(1'b0, 8'h00, 32'h0);
    compare("delay", 32'h0, rd);
  endtask
  task automatic t_flags();
    arm <= 1'b1;
    @(posedge clk_in);
    arm <= 1'b0;
    wait (cnt != 8'h00);
    apb(1'b0, 8'h04, 32'h0);
    compare("flags", 32'h0, {28'h0, rd[3:0]});
    apb(1'b0, 8'h04, 32'h0);
    compare("flags", 32'hf, {28'h0, rd[3:0]});
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, 8'(8'h10 + 4 * k), 32'h0);
      compare("data", {8'h0, sample_in[k*24 +: 24]}, {8'h0, rd[23:0]});
    end
  endtask
  task automatic t_modes();
    logic [15:0] base;
    apb(1'b1, 8'h04, 32'h0000f000);
    apb(1'b1, 8'h00, 32'h00ffc004);
    watch();
    compare("pulses", 32'h6, {24'h0, cnt});
    compare("lead", 32'h4, {16'h0, st[1] - st[0]});
    compare("lag", 32'h4, {16'h0, st[2] - st[1]});
    compare("period", 32'h20, {16'h0, st[3] - st[0]});
    base = st[0];
    apb(1'b1, 8'h04, 32'h0000f010);
    apb(1'b1, 8'h00, 32'h00ffc004);
    watch();
    compare("pulses", 32'h2, {24'h0, cnt});
    compare("first", {16'h0, base + 16'h0008}, {16'h0, st[0]});
    apb(1'b1, 8'h04, 32'h0000f000);
    apb(1'b1, 8'h00, 32'h000000f4);
    watch();
    compare("sign", 32'hc, {16'h0, st[1] - st[0]});
  endtask
  task automatic t_hard();
    apb(1'b1, 8'h08, 32'h1);
    @(posedge clk_in);
    compare("clock", 32'h1, {30'h0, xtal_en, xtal_pd});
    hard_resetn_in <= 1'b0;
    apb(1'b1, 8'h00, 32'h00000123);
    apb(1'b0, 8'h10, 32'h0);
    compare("data", 32'h0, {8'h0, rd[23:0]});
    @(posedge clk_in);
    compare("float", 32'h3, {30'h0, soe_n, oe_n});
    compare("cmp", 32'h3333, {16'h0, cmp_word});
    hard_resetn_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    compare("float", 32'h0, {30'h0, soe_n, oe_n});
    compare("clock", 32'h2, {30'h0, xtal_en, xtal_pd});
    apb(1'b0, 8'h00, 32'h0);
    compare("delay", 32'h0, rd);
    apb(1'b0, 8'h04, 32'h0);
    compare("status", 32'h0000f31f, rd);
  endtask
  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence.
  initial begin
    resetn_in = 1'b0;
    hard_resetn_in = 1'b1;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 8'h00;
    pwdata_in = 32'h0;
    arm = 1'b0;
    sample_in = 96'h123456_789abc_def012_345678;
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_defaults();
    t_flags();
    t_modes();
    t_hard();
    complete_run();
  end
  // Watchdog cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    complete_run();
  end
endmodule
